/* core/sgb_gain_switch.sv */
// Contract
// RL1: Source one, polarity zero: switched bank while request is asserted.
// RL2: Source one, polarity one: switched bank while request is deasserted.
// RL3: Sources two to four: at or above level, or at or below with polarity.
// RL4: Source five, polarity zero: switched bank on negative command direction.
// RL5: Source five, polarity one: switched bank on positive command direction.
// RL6: Sources two to four compare quantity against level one.
// RL7: Stage two mode two reuses quantity and polarity against level two.
// RL8: Levels are in kpulse/s, pulses, or r/min and mm/s, unscaled.
// RL9: Each gain passes a first-order lag, separate constants per stage.
// RL10: Three banks of thirteen values; active bank supplies all thirteen.
// RL11: Base loop gains are the manual mode stored values.
// RL12: Base vibration suppression values are the manual mode stored values.
// RL13: Software sets switched inertia equal to base when load is unchanged.
// RL14: Software uses time constants to soften large gain steps.
// RL15: Both stages true: stage two bank wins.
// RL16: Level two of zero never selects stage two bank; the code applies this only in stage two mode two with a level source.
// RL17: Option selects lag on both, none on switching, or none on return.
// RL18: Selection re-evaluated once per control cycle, outputs on that cycle; the code steps gain_out toward the new bank one control cycle later.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module sgb_gain_switch #(
   parameter int CYCLE_CLKS = sgb_pkg::CYCLE_CLKS
) (
   input  wire logic                                    clk_sys,
   input  wire logic                                    rstn,
   input  wire logic [7:0]                              avs_address,
   input  wire logic                                    avs_read,
   input  wire logic                                    avs_write,
   input  wire logic [31:0]                             avs_writedata,
   output logic [31:0]                                  avs_readdata,
   output logic                                         avs_waitrequest,
   input  wire sgb_pkg::sgb_mon_t                       mon,
   output logic [sgb_pkg::NUM_GAINS*sgb_pkg::GAIN_W-1:0] gain_out,
   output logic                                         gain_active_one,
   output logic                                         gain_active_two,
   output logic                                         cycle_tick
);
   localparam int N = sgb_pkg::NUM_GAINS;
   localparam int W = sgb_pkg::GAIN_W;
   localparam int F = sgb_pkg::FRAC_W;

   logic        rst_s1_q, rst_n_q;
   logic        pin1_a_q, pin1_q, pin2_a_q, pin2_q;
   logic [31:0] ctrl_q, lvl1_q, lvl2_q;
   logic [15:0] tc1_q, tc2_q;
   logic [W-1:0] bank_q [3][N];
   logic [$clog2(CYCLE_CLKS)-1:0] tick_cnt_q;
   logic        tick_q;
   logic        rd_pend_q;
   sgb_pkg::sgb_bank_t bank_sel_q, bank_d;
   logic [15:0] alpha_q;
   logic [W+F-1:0] filt_q [N];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // Request pins are asynchronous to clk_sys
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin1_a_q <= 1'b0;
         pin1_q   <= 1'b0;
         pin2_a_q <= 1'b0;
         pin2_q   <= 1'b0;
      end else begin
         pin1_a_q <= mon.req_pin;
         pin1_q   <= pin1_a_q;
         pin2_a_q <= mon.req2_pin;
         pin2_q   <= pin2_a_q;
      end
   end

   // Register writes
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= sgb_pkg::CTRL_RESET;
         lvl1_q <= 32'h0;
         lvl2_q <= 32'h0;
         tc1_q  <= 16'h0;
         tc2_q  <= 16'h0;
      end else if (avs_write) begin
         case (avs_address)
            sgb_pkg::ADDR_CTRL:    ctrl_q <= avs_writedata;
            // RL8: raw level units
            sgb_pkg::ADDR_LVL_ONE: lvl1_q <= avs_writedata;
            sgb_pkg::ADDR_LVL_TWO: lvl2_q <= avs_writedata;
            sgb_pkg::ADDR_TC_ONE:  tc1_q  <= avs_writedata[15:0];
            sgb_pkg::ADDR_TC_TWO:  tc2_q  <= avs_writedata[15:0];
            default: ;
         endcase
      end
   end

   // RL10: bank storage
   // RL11: base loop gains shared
   // RL12: base suppression shared
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         for (int b = 0; b < 3; b++) begin
            for (int g = 0; g < N; g++) begin
               bank_q[b][g] <= '0;
            end
         end
      end else if (avs_write && avs_address >= sgb_pkg::ADDR_BANK_BASE
                   && avs_address[5:2] < 4'(N) && avs_address[7:6] != 2'b00) begin
         bank_q[avs_address[7:6] - 2'd1][avs_address[5:2]] <= avs_writedata[W-1:0];
      end
   end

   // Read path: one wait cycle
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_pend_q    <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rd_pend_q <= avs_read && !rd_pend_q;
         if (avs_read && !rd_pend_q) begin
            case (avs_address)
               sgb_pkg::ADDR_CTRL:    avs_readdata <= ctrl_q;
               sgb_pkg::ADDR_LVL_ONE: avs_readdata <= lvl1_q;
               sgb_pkg::ADDR_LVL_TWO: avs_readdata <= lvl2_q;
               sgb_pkg::ADDR_TC_ONE:  avs_readdata <= {16'h0, tc1_q};
               sgb_pkg::ADDR_TC_TWO:  avs_readdata <= {16'h0, tc2_q};
               sgb_pkg::ADDR_STATUS:  avs_readdata <= {30'h0, bank_sel_q};
               default: begin
                  if (avs_address[7:6] != 2'b00 && avs_address[5:2] < 4'(N))
                     avs_readdata <= {{(32-W){1'b0}}, bank_q[avs_address[7:6] - 2'd1][avs_address[5:2]]};
                  else
                     avs_readdata <= 32'h0;
               end
            endcase
         end
      end
   end
   assign avs_waitrequest = avs_read && !rd_pend_q;

   // RL18: control cycle tick
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == $bits(tick_cnt_q)'(CYCLE_CLKS - 1));
         if (tick_cnt_q == $bits(tick_cnt_q)'(CYCLE_CLKS - 1))
            tick_cnt_q <= '0;
         else
            tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end
   assign cycle_tick = tick_q;

   // Condition evaluation
   logic [2:0]  src;
   logic [3:0]  src2;
   logic        pol, req1, req2, c1, c2;
   logic [31:0] qty;
   always_comb begin
      src  = ctrl_q[sgb_pkg::CTRL_SRC_LSB +: 3];
      src2 = ctrl_q[sgb_pkg::CTRL_SRC2_LSB +: 4];
      pol  = ctrl_q[sgb_pkg::CTRL_POL_BIT];
      req1 = pin1_q | mon.req_cmd;
      req2 = pin2_q | mon.req2_cmd;
      qty  = 32'h0;
      c1   = 1'b0;
      c2   = 1'b0;
      case (src)
         3'(sgb_pkg::SRC_CMD_FREQ): qty = mon.cmd_freq;
         3'(sgb_pkg::SRC_DROOP):    qty = mon.droop;
         3'(sgb_pkg::SRC_SPEED):    qty = mon.speed;
         default:                   qty = 32'h0;
      endcase
      case (src)
         // RL1: signal, polarity zero
         // RL2: signal, polarity one
         3'(sgb_pkg::SRC_SIGNAL): c1 = req1 ^ pol;
         // RL3: level compare
         // RL6: level one compare
         3'(sgb_pkg::SRC_CMD_FREQ), 3'(sgb_pkg::SRC_DROOP), 3'(sgb_pkg::SRC_SPEED):
            c1 = pol ? (qty <= lvl1_q) : (qty >= lvl1_q);
         // RL4: negative direction
         // RL5: positive direction
         3'(sgb_pkg::SRC_DIR): c1 = mon.dir_negative ^ pol;
         default: c1 = 1'b0;
      endcase
      case (src2)
         4'd1: c2 = req2;
         // RL7: same quantity, level two
         4'd2: begin
            if (src == 3'(sgb_pkg::SRC_SIGNAL))
               c2 = req2;
            else if (src >= 3'(sgb_pkg::SRC_CMD_FREQ) && src <= 3'(sgb_pkg::SRC_SPEED))
               // RL16: zero level disables
               c2 = (lvl2_q != 32'h0) && (pol ? (qty <= lvl2_q) : (qty >= lvl2_q));
            else
               c2 = c1;
         end
         default: c2 = 1'b0;
      endcase
      // RL15: stage two priority
      if (!ctrl_q[sgb_pkg::CTRL_EN_BIT])
         bank_d = sgb_pkg::BANK_BASE;
      else if (c2)
         bank_d = sgb_pkg::BANK_TWO;
      else if (c1)
         bank_d = sgb_pkg::BANK_ONE;
      else
         bank_d = sgb_pkg::BANK_BASE;
   end

   // RL18: bank latched per cycle
   // RL17: lag bypass option
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bank_sel_q <= sgb_pkg::BANK_BASE;
         alpha_q    <= 16'hffff;
      end else if (tick_q) begin
         bank_sel_q <= bank_d;
         if (bank_d != bank_sel_q) begin
            if ((ctrl_q[sgb_pkg::CTRL_TCO_LSB +: 2] == 2'(sgb_pkg::TCO_NONE_SWITCH)
                 && bank_d != sgb_pkg::BANK_BASE)
                || (ctrl_q[sgb_pkg::CTRL_TCO_LSB +: 2] == 2'(sgb_pkg::TCO_NONE_RETURN)
                 && bank_d == sgb_pkg::BANK_BASE))
               alpha_q <= 16'hffff;
            // RL9: per-stage constant
            else if (bank_d == sgb_pkg::BANK_TWO || bank_sel_q == sgb_pkg::BANK_TWO)
               alpha_q <= (tc2_q == 16'h0) ? 16'hffff : 16'(32'h0000_ffff / (32'(tc2_q) + 32'h1));
            else
               alpha_q <= (tc1_q == 16'h0) ? 16'hffff : 16'(32'h0000_ffff / (32'(tc1_q) + 32'h1));
         end
      end
   end

   // RL9: first-order lag per gain
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_lag
         logic [W+F-1:0] tgt;
         logic signed [W+F+1:0] diff;
         logic signed [W+F+17:0] step;
         assign tgt  = {bank_q[bank_sel_q][gi], {F{1'b0}}};
         assign diff = $signed({2'b00, tgt}) - $signed({2'b00, filt_q[gi]});
         assign step = (diff * $signed({1'b0, alpha_q})) >>> 16;
         always_ff @(posedge clk_sys or negedge rst_n_q) begin
            if (!rst_n_q)
               filt_q[gi] <= '0;
            else if (tick_q) begin
               if (alpha_q == 16'hffff)
                  filt_q[gi] <= tgt;
               else
                  filt_q[gi] <= (W+F)'($signed({2'b00, filt_q[gi]}) + step);
            end
         end
         assign gain_out[gi*W +: W] = filt_q[gi][W+F-1:F];
      end
   endgenerate

   assign gain_active_one = (bank_sel_q == sgb_pkg::BANK_ONE);
   assign gain_active_two = (bank_sel_q == sgb_pkg::BANK_TWO);

   // RL15: priority check
   a_stage_two_wins: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL15
      tick_q && c2 && ctrl_q[sgb_pkg::CTRL_EN_BIT] |=> bank_sel_q == sgb_pkg::BANK_TWO)
      else $error("stage two did not win");
   // RL16: zero level check
   a_level_two_zero: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL16
      tick_q && lvl2_q == 32'h0 && src2 == 4'd2 && src >= 3'(sgb_pkg::SRC_CMD_FREQ)
      && src <= 3'(sgb_pkg::SRC_SPEED) |=> bank_sel_q != sgb_pkg::BANK_TWO)
      else $error("bank two taken with zero level");
   // RL18: hold between ticks
   a_hold_between: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL18
      !tick_q |=> $stable(bank_sel_q))
      else $error("bank changed off tick");
   // RL1: signal source selects
   // RL2: inverted by polarity
   a_signal_select: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL1
      tick_q && ctrl_q[sgb_pkg::CTRL_EN_BIT] && src == 3'(sgb_pkg::SRC_SIGNAL) && src2 == 4'd0
      && req1 != pol |=> bank_sel_q == sgb_pkg::BANK_ONE)
      else $error("signal source did not select bank one");
   // RL3: level source selects
   // RL6: level one compare
   a_level_select: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL6
      tick_q && ctrl_q[sgb_pkg::CTRL_EN_BIT] && src >= 3'(sgb_pkg::SRC_CMD_FREQ)
      && src <= 3'(sgb_pkg::SRC_SPEED) && src2 == 4'd0 && (pol ? qty <= lvl1_q : qty >= lvl1_q)
      |=> bank_sel_q == sgb_pkg::BANK_ONE)
      else $error("level source did not select bank one");
   // RL4: negative direction selects
   // RL5: positive with polarity
   a_dir_select: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL4
      tick_q && ctrl_q[sgb_pkg::CTRL_EN_BIT] && src == 3'(sgb_pkg::SRC_DIR) && src2 == 4'd0
      && mon.dir_negative != pol |=> bank_sel_q == sgb_pkg::BANK_ONE)
      else $error("direction source did not select bank one");
   // RL17: entry without lag
   sequence s_switch_entry;
      tick_q && bank_d != sgb_pkg::BANK_BASE && bank_d != bank_sel_q
      && ctrl_q[sgb_pkg::CTRL_TCO_LSB +: 2] == 2'(sgb_pkg::TCO_NONE_SWITCH);
   endsequence
   sequence s_step_full;
      alpha_q == 16'hffff;
   endsequence
   a_switch_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL17
      s_switch_entry |=> s_step_full)
      else $error("lag not bypassed on switching");
   // RL17: return without lag
   sequence s_return_entry;
      tick_q && bank_d == sgb_pkg::BANK_BASE && bank_d != bank_sel_q
      && ctrl_q[sgb_pkg::CTRL_TCO_LSB +: 2] == 2'(sgb_pkg::TCO_NONE_RETURN);
   endsequence
   a_return_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n_q) // RL17
      s_return_entry |=> s_step_full)
      else $error("lag not bypassed on return");
endmodule : sgb_gain_switch

/* core/sgb_pkg.sv */
package sgb_pkg;
   // Address map, word aligned
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_LVL_ONE   = 8'h04;
   localparam logic [7:0] ADDR_LVL_TWO   = 8'h08;
   localparam logic [7:0] ADDR_TC_ONE    = 8'h0c;
   localparam logic [7:0] ADDR_TC_TWO    = 8'h10;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;
   localparam logic [7:0] ADDR_BANK_BASE = 8'h40;
   localparam logic [7:0] ADDR_BANK_STEP = 8'h40;
   // Control field positions
   localparam int CTRL_SRC_LSB   = 0;
   localparam int CTRL_POL_BIT   = 4;
   localparam int CTRL_TCO_LSB   = 8;
   localparam int CTRL_SRC2_LSB  = 16;
   localparam int CTRL_EN_BIT    = 20;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int NUM_GAINS      = 13;
   localparam int GAIN_W         = 16;
   localparam int FRAC_W         = 16;
   // Control cycle tick: 62.5 us at 125 MHz
   localparam int CLK_MHZ        = 125;
   localparam int CYCLE_NS       = 62500;
   localparam int CYCLE_CLKS     = CYCLE_NS * CLK_MHZ / 1000;

   typedef enum logic [2:0] {
      SRC_OFF, SRC_SIGNAL, SRC_CMD_FREQ, SRC_DROOP, SRC_SPEED, SRC_DIR
   } sgb_src_t;
   typedef enum logic [1:0] {
      TCO_BOTH, TCO_NONE_SWITCH, TCO_NONE_RETURN
   } sgb_tco_t;
   typedef enum logic [1:0] {
      BANK_BASE, BANK_ONE, BANK_TWO
   } sgb_bank_t;

   typedef struct packed {
      logic        req_pin;
      logic        req_cmd;
      logic        req2_pin;
      logic        req2_cmd;
      logic        dir_negative;
      logic [31:0] cmd_freq;
      logic [31:0] droop;
      logic [31:0] speed;
   } sgb_mon_t;
endpackage : sgb_pkg

/* tb/sgb_ctrl_model.sv */
`timescale 1ns/1ps
module sgb_ctrl_model (
   input  wire logic         clk_sys,
   input  wire logic [2:0]   src_sel,
   input  wire logic         req,
   input  wire logic         req2,
   input  wire logic         dir_neg,
   input  wire logic [31:0]  qty,
   output sgb_pkg::sgb_mon_t mon
);
   // Stage one request on the pin, stage two as a command, unused quantities scrambled
   always @(posedge clk_sys) begin
      mon.req_pin      <= req;
      mon.req_cmd      <= 1'b0;
      mon.req2_pin     <= 1'b0;
      mon.req2_cmd     <= req2;
      mon.dir_negative <= dir_neg;
      mon.cmd_freq     <= (src_sel == 3'h2) ? qty : ~qty;
      mon.droop        <= (src_sel == 3'h3) ? qty : ~qty;
      mon.speed        <= (src_sel == 3'h4) ? qty : ~qty;
   end
endmodule : sgb_ctrl_model

/* tb/sgb_gain_switch_tb_top.sv */
`timescale 1ns/1ps
module sgb_gain_switch_tb_top;
   logic              clk_sys = 1'b0;
   logic              rstn = 1'b0;
   logic [7:0]        avs_address = 8'h00;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [31:0]       avs_writedata = 32'h0;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   sgb_pkg::sgb_mon_t mon;
   logic [207:0]      gain_out;
   logic              cycle_tick;
   logic              gain_active_one;
   logic              gain_active_two;
   logic [2:0]        src_sel = 3'h0;
   logic              req = 1'b0;
   logic              req2 = 1'b0;
   logic              dir_neg = 1'b0;
   logic [31:0]       qty = 32'h0;
   logic [31:0]       exp_q[$];
   int                mismatches = 0;
   int                n_checks = 0;
   int                seed = 32'h4c64;
   logic [31:0]       l1;
   logic [31:0]       l2;
   int                n_ticks;

   always #4 clk_sys = ~clk_sys;

   sgb_gain_switch #(.CYCLE_CLKS(8)) sgb_gain_switch_i (
      .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mon(mon), .gain_out(gain_out),
      .gain_active_one(gain_active_one), .gain_active_two(gain_active_two), .cycle_tick(cycle_tick));

   sgb_ctrl_model sgb_ctrl_model_i (
      .clk_sys(clk_sys), .src_sel(src_sel), .req(req), .req2(req2),
      .dir_neg(dir_neg), .qty(qty), .mon(mon));

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk32

   // Read data compared against the oldest note when the slave answers
   always @(posedge clk_sys) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) chk32("unexpected read", 32'h0, 32'hffff_ffff);
         else chk32("readdata", exp_q.pop_front(), avs_readdata);
      end
   end

   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= rd;
      avs_write     <= ~rd;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b1, a, 32'h0);
   endtask : rd

   task automatic run_case(input logic [2:0] s, input logic p, input logic [3:0] s2, input logic [31:0] lv2,
                           input logic r, input logic dn, input logic [31:0] q, input logic [1:0] eb);
      bus(1'b0, sgb_pkg::ADDR_LVL_TWO, lv2);
      bus(1'b0, sgb_pkg::ADDR_CTRL, 32'h0010_0000 | (32'(s2) << 16) | (32'(p) << 4) | 32'(s));
      src_sel <= s;
      req     <= r;
      dir_neg <= dn;
      qty     <= q;
      while (cycle_tick !== 1'b1) @(posedge clk_sys);
      repeat (30) @(posedge clk_sys);
      rd(sgb_pkg::ADDR_STATUS, 32'(eb));
      chk32("gain one", 32'h1000 * (eb + 1), 32'(gain_out[31:16]));
      chk32("active banks", {30'h0, eb == 2'h2, eb == 2'h1}, {30'h0, gain_active_two, gain_active_one});
   endtask : run_case

   // One filter step after a bank change, signal source, given lag option
   task automatic lag_step(input logic [1:0] tco, input logic r, input logic part, input logic [31:0] e);
      bus(1'b0, sgb_pkg::ADDR_CTRL, 32'h0010_0001 | (32'(tco) << 8));
      req <= r;
      while (gain_active_one !== r) @(posedge clk_sys);
      do @(posedge clk_sys); while (cycle_tick !== 1'b1);
      @(posedge clk_sys);
      if (part) chk32("lag partial", 32'h1, 32'(gain_out[31:16] > 16'h1000 && gain_out[31:16] < 16'h2000));
      else chk32("lag bypass", e, 32'(gain_out[31:16]));
   endtask : lag_step

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   initial begin
      #400000;
      mismatches++;
      print_verdict();
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      do @(posedge clk_sys); while (cycle_tick !== 1'b1);
      n_ticks = 0;
      do begin
         @(posedge clk_sys);
         n_ticks++;
      end while (cycle_tick !== 1'b1);
      chk32("tick period", 32'h8, 32'(n_ticks));
      rd(sgb_pkg::ADDR_CTRL, sgb_pkg::CTRL_RESET);
      rd(sgb_pkg::ADDR_STATUS, 32'h0);
      rd(8'h3c, 32'h0);
      l1 = 32'h100 + ($random(seed) & 32'hff);
      l2 = l1 + 32'h100 + ($random(seed) & 32'hff);
      bus(1'b0, sgb_pkg::ADDR_LVL_ONE, l1);
      for (int b = 0; b < 3; b++) begin
         bus(1'b0, 8'h40 + 8'(b * 64), 32'h0123);
         bus(1'b0, 8'h44 + 8'(b * 64), 32'h1000 * (b + 1));
      end
      rd(8'h84, 32'h2000);
      bus(1'b0, sgb_pkg::ADDR_TC_ONE, 32'h0);
      run_case(3'h1, 1'b0, 4'h0, 32'h0, 1'b1, 1'b0, 32'h0, 2'h1);
      run_case(3'h1, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, 32'h0, 2'h0);
      run_case(3'h1, 1'b1, 4'h0, 32'h0, 1'b0, 1'b0, 32'h0, 2'h1);
      run_case(3'h1, 1'b1, 4'h0, 32'h0, 1'b1, 1'b0, 32'h0, 2'h0);
      run_case(3'h2, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, l1, 2'h1);
      run_case(3'h3, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, l1 - 1, 2'h0);
      run_case(3'h4, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, l1 + 5, 2'h1);
      run_case(3'h4, 1'b1, 4'h0, 32'h0, 1'b0, 1'b0, l1, 2'h1);
      run_case(3'h4, 1'b1, 4'h0, 32'h0, 1'b0, 1'b0, l1 + 1, 2'h0);
      run_case(3'h5, 1'b0, 4'h0, 32'h0, 1'b0, 1'b1, 32'h0, 2'h1);
      run_case(3'h5, 1'b1, 4'h0, 32'h0, 1'b0, 1'b0, 32'h0, 2'h1);
      run_case(3'h5, 1'b1, 4'h0, 32'h0, 1'b0, 1'b1, 32'h0, 2'h0);
      run_case(3'h4, 1'b0, 4'h2, l2, 1'b0, 1'b0, l2, 2'h2);
      run_case(3'h4, 1'b0, 4'h2, l2, 1'b0, 1'b0, l2 - 1, 2'h1);
      run_case(3'h4, 1'b0, 4'h2, 32'h0, 1'b0, 1'b0, l2, 2'h1);
      req2 <= 1'b1;
      run_case(3'h1, 1'b0, 4'h1, 32'h0, 1'b1, 1'b0, 32'h0, 2'h2);
      run_case(3'h1, 1'b0, 4'h2, 32'h0, 1'b0, 1'b0, 32'h0, 2'h2);
      req2 <= 1'b0;
      run_case(3'h0, 1'b0, 4'h0, 32'h0, 1'b1, 1'b1, l2, 2'h0);
      bus(1'b0, sgb_pkg::ADDR_TC_ONE, 32'h3);
      lag_step(2'h0, 1'b1, 1'b1, 32'h0);
      lag_step(2'h2, 1'b0, 1'b0, 32'h1000);
      lag_step(2'h1, 1'b1, 1'b0, 32'h2000);
      repeat (4) @(posedge clk_sys);
      print_verdict();
   end
endmodule : sgb_gain_switch_tb_top
